// [hw/ocr_filter.sv]
// Off-core response event filter and precise sample record writer
// Operation
// - Word at 0B0H holds the retired triggering instruction address.
// - Record word at offset 08H carries the next instruction address.
// - Filter holds request type 15:0, supplier 30:16, snoop 37:31.
// - Request bit 0 selects demand data and page-table line reads.
// - Request bit 1 selects demand and first-level ownership reads.
// - Request bit 2 selects demand and first-level code line reads.
// - Request bits 4, 5, 6 select second-level prefetch reads.
// - Request bit 15 selects any other core-uncore request, including I/O.
// - Supplier bit 16 matches every response type.
// - Supplier bit 17 matches responses without supplier information.
// - Supplier bits 18-20 match third-level modified, exclusive, shared hits.
// - First variant: bit 22 local memory, bits 21 and 30:23 reserved.
// - Fourth-level variant: bits 22-25 fourth cache hits, 30:26 reserved.
module ocr_filter #(
    parameter int VARIANT = ocr_pkg::VAR_LMC
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  filt_wr_en,
    input  wire logic [63:0]           filt_wr_data,
    output logic      [63:0]           filt_rd_data_q,
    input  wire logic                  rsp_valid,
    input  wire ocr_pkg::ocr_rsp_s     rsp_info,
    output logic                       event_count_q,
    input  wire logic                  assist_req,
    input  wire ocr_pkg::ocr_ip_s      assist_ip,
    output logic                       assist_busy_q,
    output logic                       rec_wr_q,
    output logic      [7:0]            rec_offset_q,
    output logic      [63:0]           rec_data_q
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (VARIANT != ocr_pkg::VAR_LMC
            && VARIANT != ocr_pkg::VAR_L4C) begin : g_bad
        $error("VARIANT must be 0 or 1");
    end

    // ------------------------------------------------------------
    // Filter register
    // ------------------------------------------------------------
    localparam logic [63:0] WR_MASK = (VARIANT == ocr_pkg::VAR_L4C) ?
        ocr_pkg::WR_MASK_L4C : ocr_pkg::WR_MASK_LMC;

    logic [63:0] filt_q;
    logic [63:0] filt_d;

    assign filt_d = filt_wr_en ? (filt_wr_data & WR_MASK) : filt_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_q         <= ocr_pkg::FILT_RST;
            filt_rd_data_q <= ocr_pkg::FILT_RST;
        end else begin
            filt_q         <= filt_d;
            filt_rd_data_q <= filt_d;
        end
    end

    // ------------------------------------------------------------
    // Response qualification
    // ------------------------------------------------------------
    wire [ocr_pkg::REQ_W-1:0]   req_sel;
    wire [ocr_pkg::SUPP_W-1:0]  supp_sel;
    wire [ocr_pkg::SNOOP_W-1:0] snoop_sel;
    wire                        any_rsp;
    wire                        req_hit;
    wire                        supp_hit;
    wire                        snoop_hit;
    wire                        count_d;

    assign req_sel   = filt_q[ocr_pkg::REQ_MSB:ocr_pkg::REQ_LSB];
    assign supp_sel  = filt_q[ocr_pkg::SUPP_MSB:ocr_pkg::SUPP_LSB];
    assign snoop_sel = filt_q[ocr_pkg::SNOOP_MSB:ocr_pkg::SNOOP_LSB];
    assign any_rsp   = filt_q[ocr_pkg::BIT_ANY_RSP];

    // Request bits 0-2, 4-6 and 15 each pick one class of request
    assign req_hit = |(req_sel & rsp_info.req_type);

    // Reserved supplier bits are never stored, so they never match
    assign supp_hit = any_rsp ||
        |(supp_sel & rsp_info.supplier);
    assign snoop_hit = |(snoop_sel & rsp_info.snoop);

    assign count_d = rsp_valid && req_hit
                     && (supp_hit || snoop_hit);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            event_count_q <= 1'h0;
        end else begin
            event_count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // Sample record writer
    // ------------------------------------------------------------
    ocr_pkg::ocr_rec_st_e st_q;
    ocr_pkg::ocr_rec_st_e st_d;
    logic [63:0]          trig_ip_q;
    logic [63:0]          trig_ip_d;
    wire                  take;

    assign take = (st_q == ocr_pkg::REC_IDLE) && assist_req;
    assign trig_ip_d = take ? assist_ip.trigger_instruction_pointer
                            : trig_ip_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ocr_pkg::REC_IDLE: begin
                if (assist_req) begin
                    st_d = ocr_pkg::REC_NEXT;
                end
            end
            ocr_pkg::REC_NEXT: begin
                st_d = ocr_pkg::REC_TRIG;
            end
            ocr_pkg::REC_TRIG: begin
                st_d = ocr_pkg::REC_IDLE;
            end
            default: begin
                st_d = ocr_pkg::REC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q      <= ocr_pkg::REC_IDLE;
            trig_ip_q <= 64'h0;
        end else begin
            st_q      <= st_d;
            trig_ip_q <= trig_ip_d;
        end
    end

    // Next address goes out first, triggering address second
    wire        wr_next;
    wire        wr_trig;
    wire [7:0]  off_d;
    wire [63:0] data_d;

    assign wr_next = take;
    assign wr_trig = (st_q == ocr_pkg::REC_NEXT);
    assign off_d = wr_next ? ocr_pkg::REC_NEXT_IP_OFF :
                   wr_trig ? ocr_pkg::REC_TRIG_IP_OFF :
                   ocr_pkg::REC_OFF_RST;
    assign data_d = wr_next ? assist_ip.next_instruction_pointer :
                    wr_trig ? trig_ip_q :
                    64'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rec_wr_q      <= 1'h0;
            rec_offset_q  <= ocr_pkg::REC_OFF_RST;
            rec_data_q    <= 64'h0;
            assist_busy_q <= 1'h0;
        end else begin
            rec_wr_q      <= wr_next || wr_trig;
            rec_offset_q  <= off_d;
            rec_data_q    <= data_d;
            assist_busy_q <= (st_d != ocr_pkg::REC_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rec_next_ip: assert property (
        take |=> rec_wr_q && rec_offset_q == ocr_pkg::REC_NEXT_IP_OFF
            && rec_data_q == $past(assist_ip.next_instruction_pointer))
        else $error("next address word wrong");

    a_rec_trig_ip: assert property (
        take |=> ##1 rec_wr_q
            && rec_offset_q == ocr_pkg::REC_TRIG_IP_OFF
            && rec_data_q == $past(assist_ip.trigger_instruction_pointer, 2))
        else $error("trigger address word wrong");

    a_filt_layout: assert property (
        filt_wr_en |=> filt_rd_data_q == ($past(filt_wr_data) & WR_MASK))
        else $error("filter readback wrong");

    a_rsvd_zero: assert property (
        (filt_rd_data_q & ~WR_MASK) == 64'h0)
        else $error("reserved bits not zero");

    a_req_demand_rd: assert property (
        rsp_valid && rsp_info.req_type == 16'h0001
            && filt_q[ocr_pkg::BIT_DMND_DATA] && any_rsp |=> event_count_q)
        else $error("demand data read not counted");

    a_req_demand_own: assert property (
        rsp_valid && rsp_info.req_type == 16'h0002
            && !filt_q[ocr_pkg::BIT_DMND_OWN] |=> !event_count_q)
        else $error("ownership read counted while deselected");

    a_req_demand_code: assert property (
        rsp_valid && rsp_info.req_type == 16'h0004
            && filt_q[ocr_pkg::BIT_DMND_CODE] && any_rsp |=> event_count_q)
        else $error("code read not counted");

    a_req_prefetch: assert property (
        rsp_valid && rsp_info.req_type == 16'h0010
            && filt_q[ocr_pkg::BIT_PF_DATA] && !filt_q[ocr_pkg::BIT_PF_OWN]
            && any_rsp |=> event_count_q)
        else $error("prefetch data read not counted");

    a_req_other: assert property (
        rsp_valid && rsp_info.req_type == 16'h8000
            && filt_q[ocr_pkg::BIT_REQ_OTHER] && any_rsp |=> event_count_q)
        else $error("other request not counted");

    a_any_rsp: assert property (
        rsp_valid && req_hit && any_rsp |=> event_count_q)
        else $error("catch-all did not match");

    a_no_supplier: assert property (
        rsp_valid && req_hit && rsp_info.supplier == 15'h0002
            && filt_q[ocr_pkg::BIT_NO_SUPPLIER_SEL] |=> event_count_q)
        else $error("no-supplier response missed");

    a_llc_hits: assert property (
        rsp_valid && req_hit && rsp_info.supplier == 15'h0008
            && filt_q[ocr_pkg::BIT_LLC_EXCL] |=> event_count_q)
        else $error("exclusive hit missed");

    a_lmc_reserved: assert property (
        (VARIANT == ocr_pkg::VAR_LMC) |-> filt_q[30:23] == 8'h00
            && !filt_q[21])
        else $error("reserved supplier bit stored");

    a_l4_hop0: assert property (
        (VARIANT == ocr_pkg::VAR_L4C) && rsp_valid && req_hit
            && rsp_info.supplier == 15'h0080
            && filt_q[ocr_pkg::BIT_L4_HOP0] |=> event_count_q)
        else $error("fourth cache hop0 hit missed");

    a_need_req_hit: assert property (
        !(rsp_valid && req_hit) |=> !event_count_q)
        else $error("count without request match");

    a_llc_modified: assert property (
        rsp_valid && req_hit && rsp_info.supplier == 15'h0004
            && filt_q[ocr_pkg::BIT_LLC_MOD] |=> event_count_q)
        else $error("modified hit missed");

    a_llc_shared: assert property (
        rsp_valid && req_hit && rsp_info.supplier == 15'h0010
            && filt_q[ocr_pkg::BIT_LLC_SHRD] |=> event_count_q)
        else $error("shared hit missed");

    a_lmc_local: assert property (
        (VARIANT == ocr_pkg::VAR_LMC) && rsp_valid && req_hit
            && rsp_info.supplier == 15'h0040
            && filt_q[ocr_pkg::BIT_LOCAL_MEM] |=> event_count_q)
        else $error("local memory response missed");

    a_l4_reserved: assert property (
        (VARIANT == ocr_pkg::VAR_L4C) |-> filt_q[30:26] == 5'h00
            && !filt_q[21])
        else $error("reserved fourth cache bit stored");

    a_l4_far: assert property (
        (VARIANT == ocr_pkg::VAR_L4C) && rsp_valid && req_hit
            && rsp_info.supplier == 15'h0200
            && filt_q[ocr_pkg::BIT_L4_FAR] |=> event_count_q)
        else $error("fourth cache far hit missed");

    a_snoop_match: assert property (
        rsp_valid && req_hit && !supp_hit && snoop_hit |=> event_count_q)
        else $error("snoop match not counted");

    a_no_sel_match: assert property (
        rsp_valid && !supp_hit && !snoop_hit |=> !event_count_q)
        else $error("count without supplier or snoop match");

    a_pf_code: assert property (
        rsp_valid && rsp_info.req_type == 16'h0040
            && !filt_q[ocr_pkg::BIT_PF_CODE] |=> !event_count_q)
        else $error("prefetch code read counted while deselected");

    a_rec_idle: assert property (
        !rec_wr_q |-> rec_offset_q == ocr_pkg::REC_OFF_RST
            && rec_data_q == 64'h0)
        else $error("record output not idle");

    a_busy_window: assert property (
        take |=> assist_busy_q [*2] ##1 !assist_busy_q)
        else $error("busy window wrong");

    c_count: cover property (rsp_valid ##1 event_count_q);
    c_record: cover property (take ##2 rec_wr_q);
    c_refused: cover property (assist_busy_q && assist_req);
    c_snoop_only: cover property (
        rsp_valid && req_hit && !supp_hit && snoop_hit);

endmodule

// [include/ocr_pkg.sv]
// Constants and types for the off-core response filter block
package ocr_pkg;

    // ------------------------------------------------------------
    // Filter register layout
    // ------------------------------------------------------------
    localparam int FILT_W      = 64;
    localparam int REQ_LSB     = 0;
    localparam int REQ_MSB     = 15;
    localparam int SUPP_LSB    = 16;
    localparam int SUPP_MSB    = 30;
    localparam int SNOOP_LSB   = 31;
    localparam int SNOOP_MSB   = 37;
    localparam int REQ_W       = REQ_MSB - REQ_LSB + 1;
    localparam int SUPP_W      = SUPP_MSB - SUPP_LSB + 1;
    localparam int SNOOP_W     = SNOOP_MSB - SNOOP_LSB + 1;

    // Request type bit positions
    localparam int BIT_DMND_DATA   = 0;
    localparam int BIT_DMND_OWN    = 1;
    localparam int BIT_DMND_CODE   = 2;
    localparam int BIT_PF_DATA     = 4;
    localparam int BIT_PF_OWN      = 5;
    localparam int BIT_PF_CODE     = 6;
    localparam int BIT_REQ_OTHER   = 15;

    // Supplier bit positions
    localparam int BIT_ANY_RSP     = 16;
    localparam int BIT_NO_SUPPLIER_SEL     = 17;
    localparam int BIT_LLC_MOD     = 18;
    localparam int BIT_LLC_EXCL    = 19;
    localparam int BIT_LLC_SHRD    = 20;
    localparam int BIT_LOCAL_MEM   = 22;
    localparam int BIT_L4_LOCAL    = 22;
    localparam int BIT_L4_HOP0     = 23;
    localparam int BIT_L4_HOP1     = 24;
    localparam int BIT_L4_FAR      = 25;

    // Writable bits per product variant; all others read as zero
    localparam logic [63:0] WR_MASK_LMC = 64'h0000_003f_805f_8077;
    localparam logic [63:0] WR_MASK_L4C = 64'h0000_003f_83df_8077;
    localparam logic [63:0] FILT_RST    = 64'h0000_0000_0000_0000;

    // Product variants
    localparam int VAR_LMC = 0;
    localparam int VAR_L4C = 1;

    // ------------------------------------------------------------
    // Sampling record offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REC_NEXT_IP_OFF = 8'h08;
    localparam logic [7:0] REC_TRIG_IP_OFF = 8'hb0;
    localparam logic [7:0] REC_OFF_RST     = 8'h00;
    localparam int         IP_W            = 64;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SNOOP_W-1:0] snoop;
        logic [SUPP_W-1:0]  supplier;
        logic [REQ_W-1:0]   req_type;
    } ocr_rsp_s;

    typedef struct packed {
        logic [IP_W-1:0] trigger_instruction_pointer;
        logic [IP_W-1:0] next_instruction_pointer;
    } ocr_ip_s;

    typedef enum logic [1:0] {
        REC_IDLE = 2'h0,
        REC_NEXT = 2'h1,
        REC_TRIG = 2'h3
    } ocr_rec_st_e;

endpackage

// [testbench/ocr_filter_tb.sv]
// Self-checking bench for the off-core response filter
module ocr_filter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic              clk;
    logic              sys_rst;
    logic              filt_wr_en;
    logic [63:0]       filt_wr_data;
    logic [63:0]       filt_rd_data_q;
    logic              rsp_valid;
    ocr_pkg::ocr_rsp_s rsp_info;
    logic              event_count_q;
    logic              assist_req;
    ocr_pkg::ocr_ip_s  assist_ip;
    logic              assist_busy_q;
    logic              rec_wr_q;
    logic [7:0]        rec_offset_q;
    logic [63:0]       rec_data_q;
    int                num_errors;
    int                n_compared;
    logic [63:0]       l4_rd_data_q;
    logic              l4_count_q;
    logic [63:0]       rec_status;

    assign rec_status = {54'h0, assist_busy_q, rec_wr_q, rec_offset_q};

    ocr_filter dut (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .filt_wr_en     (filt_wr_en),
        .filt_wr_data   (filt_wr_data),
        .filt_rd_data_q (filt_rd_data_q),
        .rsp_valid      (rsp_valid),
        .rsp_info       (rsp_info),
        .event_count_q  (event_count_q),
        .assist_req     (assist_req),
        .assist_ip      (assist_ip),
        .assist_busy_q  (assist_busy_q),
        .rec_wr_q       (rec_wr_q),
        .rec_offset_q   (rec_offset_q),
        .rec_data_q     (rec_data_q)
    );

    ocr_filter #(
        .VARIANT (ocr_pkg::VAR_L4C)
    ) dut_l4 (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .filt_wr_en     (filt_wr_en),
        .filt_wr_data   (filt_wr_data),
        .filt_rd_data_q (l4_rd_data_q),
        .rsp_valid      (rsp_valid),
        .rsp_info       (rsp_info),
        .event_count_q  (l4_count_q),
        .assist_req     (assist_req),
        .assist_ip      (assist_ip),
        .assist_busy_q  (),
        .rec_wr_q       (),
        .rec_offset_q   (),
        .rec_data_q     ()
    );

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr_filt(input logic [63:0] d);
        @(posedge clk);
        filt_wr_en   <= 1'h1;
        filt_wr_data <= d;
        @(posedge clk);
        filt_wr_en   <= 1'h0;
    endtask

    task automatic send_rsp(input logic [37:0] v, input logic exp);
        @(posedge clk);
        rsp_valid <= 1'h1;
        rsp_info  <= ocr_pkg::ocr_rsp_s'(v);
        @(posedge clk);
        rsp_valid <= 1'h0;
        #1;
        chk_bit(event_count_q, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        #1;
        chk_word(filt_rd_data_q, 64'h0);
        chk_word(rec_status, 64'h0);
        wr_filt(64'hffff_ffff_ffff_ffff);
        repeat (2) @(posedge clk);
        #1;
        chk_word(filt_rd_data_q, ocr_pkg::WR_MASK_LMC);
        chk_word(l4_rd_data_q, ocr_pkg::WR_MASK_L4C);
    endtask

    task automatic test_req_bits;
        int rb[7] = '{0, 1, 2, 4, 5, 6, 15};
        foreach (rb[i]) begin
            wr_filt((64'h1 << rb[i]) | 64'h1_0000);
            send_rsp((38'h1 << rb[i]) | 38'h4_0000, 1'h1);
            send_rsp(rb[i] == 0 ? 38'h2 : 38'h1, 1'h0);
        end
        send_rsp(38'h0008, 1'h0);
    endtask

    task automatic test_supp_bits;
        int sb[5] = '{17, 18, 19, 20, 22};
        foreach (sb[i]) begin
            wr_filt(64'h1 | (64'h1 << sb[i]));
            send_rsp(38'h1 | (38'h1 << sb[i]), 1'h1);
            send_rsp(38'h1 | (38'h1 << (sb[i] == 17 ? 18 : 17)),
                     1'h0);
        end
        wr_filt(64'h1 | (64'h1 << 31));
        send_rsp(38'h1 | (38'h1 << 31), 1'h1);
        send_rsp(38'h1 | (38'h1 << 32), 1'h0);
        wr_filt(64'h1_0001);
        send_rsp(38'h1, 1'h1);
        send_rsp(38'h2_0002, 1'h0);
    endtask

    task automatic test_b2b;
        logic        exp[3] = '{1'h1, 1'h0, 1'h1};
        logic [37:0] seq[3] = '{38'h1, 38'h4, 38'h1};
        @(posedge clk);
        rsp_valid <= 1'h1;
        rsp_info  <= ocr_pkg::ocr_rsp_s'(seq[0]);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            if (i < 2) begin
                rsp_info <= ocr_pkg::ocr_rsp_s'(seq[i + 1]);
            end else begin
                rsp_valid <= 1'h0;
            end
            #1;
            chk_bit(event_count_q, exp[i]);
        end
    endtask

    task automatic test_l4;
        for (int b = 22; b < 26; b++) begin
            wr_filt(64'h1 | (64'h1 << b));
            @(posedge clk);
            rsp_valid <= 1'h1;
            rsp_info  <= ocr_pkg::ocr_rsp_s'(38'h1 | (38'h1 << b));
            @(posedge clk);
            rsp_valid <= 1'h0;
            #1;
            chk_bit(l4_count_q, 1'h1);
            chk_bit(event_count_q, b == 22);
        end
    endtask

    task automatic test_record;
        logic [63:0] trig = 64'h1234_5678_9abc_def0;
        logic [63:0] nxt  = 64'h0fed_cba9_8765_4321;
        @(posedge clk);
        assist_req <= 1'h1;
        assist_ip  <= {trig, nxt};
        @(posedge clk);
        assist_ip  <= {nxt, trig};
        #1;
        chk_word(rec_status, 64'h308);
        chk_word(rec_data_q, nxt);
        @(posedge clk);
        assist_req <= 1'h0;
        #1;
        chk_word(rec_status, 64'h3b0);
        chk_word(rec_data_q, trig);
        @(posedge clk);
        #1;
        chk_word(rec_status, 64'h0);
        chk_word(rec_data_q, 64'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk          = 1'h0;
        sys_rst      = 1'h1;
        filt_wr_en   = 1'h0;
        filt_wr_data = 64'h0;
        rsp_valid    = 1'h0;
        rsp_info     = ocr_pkg::ocr_rsp_s'(38'h0);
        assist_req   = 1'h0;
        assist_ip    = ocr_pkg::ocr_ip_s'(128'h0);
        num_errors   = 0;
        n_compared   = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        test_regs();
        test_req_bits();
        test_supp_bits();
        test_b2b();
        test_l4();
        test_record();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule
